// ==== module_advertising_rom.sv ====
/*
  Read-only advertising store of a pluggable module, served to a host over
  the two-wire serial management bus, gated by the module select line.
  Assumes scl, sda and the select line come from pins in another clock
  domain, and that the retained-store programming port is driven by local
  logic on core_clk.
*/
// What this block does
// - Far-end byte low five bits give lane grouping; reserved codes 27-31 never sent.
// - Media technology byte is a code 00h-0Fh; 10h upward reserved.
// - Lower upper page check byte is low eight bits of sum of bytes 128-221.
// - Custom area 223-255 lives in retained storage, kept through reset.
// - Lower page byte 2 bit 7 tells whether the second upper page exists.
// - Second upper page is read-only and static; repeated reads match.
// - Byte 255 of second upper page checks bytes 130 through 254.
// - Firmware revisions outside that check, hardware revisions inside; all numeric.
// - Single-mode length: multiplier bits 7-6, base bits 5-0, in kilometres.
// - Three upper multimode lengths count 2 m, lowest grade 1 m; next reserved.
// - Unsupported fiber lengths read zero; cable assemblies zero all of them.
// - Nominal wavelength 16 bits, 0.05 nm units, MSB at 138, LSB at 139.
// - Wavelength tolerance 16 bits, 0.005 nm units, MSB at 140, LSB at 141.
// - Select wait byte: mantissa in bits 4-0, exponent in bits 7-5.
// - Wait time at byte 143 is mantissa shifted left by exponent, in microseconds.
`timescale 1ns/1ps
`default_nettype none

module module_advertising_rom #(
  parameter logic [6:0] BUS_ADDR = adv_rom_pkg::DEF_BUS_ADDR,
  parameter logic PAGE1_PRESENT = 1'b1,
  parameter logic IS_CABLE_ASSEMBLY = 1'b0,
  parameter logic [4:0] FAR_END_CODE = adv_rom_pkg::DEF_FAR_END,
  parameter logic [7:0] MEDIA_TECH = adv_rom_pkg::DEF_MEDIA_TECH,
  parameter logic [7:0] CUSTOM_BYTE = adv_rom_pkg::DEF_CUSTOM_BYTE,
  parameter logic [7:0] PAGE0_LOW_SUM = adv_rom_pkg::DEF_PAGE0_LOW_SUM,
  parameter logic [7:0] FW_MAJOR = adv_rom_pkg::DEF_REVISION,
  parameter logic [7:0] FW_MINOR = adv_rom_pkg::DEF_REVISION,
  parameter logic [7:0] HW_MAJOR = adv_rom_pkg::DEF_REVISION,
  parameter logic [7:0] HW_MINOR = adv_rom_pkg::DEF_REVISION,
  parameter logic [1:0] SMF_MULT = adv_rom_pkg::DEF_SMF_MULT,
  parameter logic [5:0] SMF_BASE = adv_rom_pkg::DEF_SMF_BASE,
  parameter logic [7:0] MM5_LEN = adv_rom_pkg::DEF_MM_LEN,
  parameter logic [7:0] MM4_LEN = adv_rom_pkg::DEF_MM_LEN,
  parameter logic [7:0] MM3_LEN = adv_rom_pkg::DEF_MM_LEN,
  parameter logic [7:0] MM2_LEN = adv_rom_pkg::DEF_MM_LEN,
  parameter logic [15:0] WAVELENGTH = adv_rom_pkg::DEF_WAVELENGTH,
  parameter logic [15:0] WAVE_TOL = adv_rom_pkg::DEF_WAVE_TOL,
  parameter logic [2:0] WAIT_EXP = adv_rom_pkg::DEF_WAIT_EXP,
  parameter logic [4:0] WAIT_MANT = adv_rom_pkg::DEF_WAIT_MANT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic module_select_line_n,
  input wire logic nv_prog_we,
  input wire logic [adv_rom_pkg::NV_AW-1:0] nv_prog_addr,
  input wire logic [7:0] nv_prog_data,
  output logic sda_o,
  output logic sda_oe
);
  import adv_rom_pkg::*;

  // ************************************************************
  // Static contents and check bytes.
  // ************************************************************
  localparam logic [7:0] FAR_END_BYTE =
    (FAR_END_CODE >= FAR_END_FIRST_RSVD) ? RST_BYTE : {3'h0, FAR_END_CODE};
  localparam logic [7:0] MEDIA_BYTE =
    (MEDIA_TECH >= MEDIA_FIRST_RSVD) ? MEDIA_OTHERS : MEDIA_TECH;
  localparam logic SMF_OK = (SMF_MULT == SMF_MULT_TENTH) || (SMF_MULT == SMF_MULT_ONE);
  localparam logic [7:0] SMF_BYTE =
    (IS_CABLE_ASSEMBLY || !SMF_OK) ? RST_BYTE : {SMF_MULT, SMF_BASE};
  localparam logic [7:0] MM5_BYTE = IS_CABLE_ASSEMBLY ? RST_BYTE : MM5_LEN;
  localparam logic [7:0] MM4_BYTE = IS_CABLE_ASSEMBLY ? RST_BYTE : MM4_LEN;
  localparam logic [7:0] MM3_BYTE = IS_CABLE_ASSEMBLY ? RST_BYTE : MM3_LEN;
  localparam logic [7:0] MM2_BYTE = IS_CABLE_ASSEMBLY ? RST_BYTE : MM2_LEN;
  localparam logic [7:0] WAIT_BYTE = {WAIT_EXP, WAIT_MANT};

  // Bytes 213-220 are reserved and read zero, so they add nothing.
  localparam logic [7:0] PAGE0_CHECK =
    8'(PAGE0_LOW_SUM + FAR_END_BYTE + MEDIA_BYTE + CUSTOM_BYTE);

  // Firmware revisions stay out so firmware can change them freely.
  localparam logic [7:0] PAGE1_CHECK = 8'(HW_MAJOR + HW_MINOR + SMF_BYTE + MM5_BYTE
    + MM4_BYTE + MM3_BYTE + MM2_BYTE + WAVELENGTH[15:8] + WAVELENGTH[7:0]
    + WAVE_TOL[15:8] + WAVE_TOL[7:0] + WAIT_BYTE);

  // ************************************************************
  // Pin synchronisers with agreement filter.
  // ************************************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_f_q;
  logic [2:0] pin_p_q;

  assign pin_raw = {module_select_line_n, sda_i, scl_i};

  for (genvar g = 0; g < 3; g++) begin : g_pin
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        sync1_q[g] <= PIN_IDLE[g];
        sync2_q[g] <= PIN_IDLE[g];
        sync3_q[g] <= PIN_IDLE[g];
        pin_f_q[g] <= PIN_IDLE[g];
        pin_p_q[g] <= PIN_IDLE[g];
      end else begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
        sync3_q[g] <= sync2_q[g];
        if (sync2_q[g] == sync3_q[g]) begin
          pin_f_q[g] <= sync3_q[g];
        end
        pin_p_q[g] <= pin_f_q[g];
      end
    end
  end

  logic scl_f;
  logic sda_f;
  logic selected;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_f = pin_f_q[0];
  assign sda_f = pin_f_q[1];
  assign selected = ~pin_f_q[2];
  assign scl_rise = scl_f & ~pin_p_q[0];
  assign scl_fall = ~scl_f & pin_p_q[0];
  assign bus_start = scl_f & pin_p_q[0] & pin_p_q[1] & ~sda_f;
  assign bus_stop = scl_f & pin_p_q[0] & ~pin_p_q[1] & sda_f;

  // ************************************************************
  // Serial slave state machine.
  // ************************************************************
  slave_state_e state_q;
  slave_state_e ack_next_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] rd_byte_q;
  logic active;
  logic byte_in;
  logic read_load;

  assign active = selected & ~bus_stop & ~bus_start;
  assign byte_in = active & scl_fall & (bit_cnt_q == BITS_PER_BYTE);
  assign read_load = active & scl_fall
    & (((state_q == ST_ACK) && (ack_next_q == ST_READ)) || (state_q == ST_RACK));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      ack_next_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= RST_BYTE;
      tx_q <= RST_BYTE;
      sda_oe <= 1'b0;
    end else if (!selected || bus_stop) begin
      state_q <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state_q <= ST_DEV_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_DEV_ADDR, ST_OFFSET, ST_WDATA: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
          end else if (byte_in) begin
            if (state_q != ST_DEV_ADDR) begin
              sda_oe <= 1'b1;
              state_q <= ST_ACK;
              ack_next_q <= ST_WDATA;
            end else if (shift_q[7:1] == BUS_ADDR) begin
              sda_oe <= 1'b1;
              state_q <= ST_ACK;
              ack_next_q <= shift_q[0] ? ST_READ : ST_OFFSET;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            state_q <= ack_next_q;
            if (ack_next_q == ST_READ) begin
              tx_q <= rd_byte_q;
              sda_oe <= ~rd_byte_q[7];
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
          end else if (scl_fall) begin
            if (bit_cnt_q == BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              sda_oe <= ~tx_q[3'(4'h7 - bit_cnt_q)];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_f) begin
            state_q <= ST_IDLE;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            tx_q <= rd_byte_q;
            sda_oe <= ~rd_byte_q[7];
            state_q <= ST_READ;
          end
        end
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // The pin is open drain: the slave only ever pulls it low.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ************************************************************
  // Byte offset and page selection.
  // ************************************************************
  logic [7:0] offset_q;
  logic [7:0] page_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_q <= RST_BYTE;
      page_q <= PAGE_ZERO;
    end else if (byte_in && (state_q == ST_OFFSET)) begin
      offset_q <= shift_q;
    end else if (byte_in && (state_q == ST_WDATA)) begin
      // Only the page selector takes data; every advertising byte ignores writes.
      if (offset_q == OFF_PAGE_SELECT) begin
        page_q <= shift_q;
      end
      offset_q <= 8'(offset_q + 8'h01);
    end else if (read_load) begin
      offset_q <= 8'(offset_q + 8'h01);
    end
  end

  // ************************************************************
  // Retained custom area.
  // ************************************************************
  logic [NV_AW-1:0] nv_raddr;
  logic [7:0] nv_rdata;
  logic [7:0] nv_index;

  assign nv_index = 8'(offset_q - OFF_NV_FIRST);
  assign nv_raddr = nv_index[NV_AW-1:0];

  // The host has no write path here; only the local programming port fills it.
  nv_store u_nv_store (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(nv_prog_we),
    .wr_addr(nv_prog_addr),
    .wr_data(nv_prog_data),
    .rd_addr(nv_raddr),
    .rd_data_q(nv_rdata)
  );

  // ************************************************************
  // Read data selection.
  // ************************************************************
  logic [7:0] map_byte;

  always_comb begin
    map_byte = RST_BYTE;
    if (offset_q < OFF_UPPER_FIRST) begin
      if (offset_q == OFF_LOWER_STATUS) begin
        map_byte[FLAT_MEM_BIT] = ~PAGE1_PRESENT;
      end else if (offset_q == OFF_PAGE_SELECT) begin
        map_byte = page_q;
      end
    end else if (page_q == PAGE_ZERO) begin
      if (offset_q >= OFF_NV_FIRST) begin
        map_byte = nv_rdata;
      end else begin
        case (offset_q)
          OFF_FAR_END: map_byte = FAR_END_BYTE;
          OFF_MEDIA_TECH: map_byte = MEDIA_BYTE;
          OFF_CUSTOM_BYTE: map_byte = CUSTOM_BYTE;
          OFF_PAGE0_CHECK: map_byte = PAGE0_CHECK;
          default: map_byte = RST_BYTE;
        endcase
      end
    end else if ((page_q == PAGE_ONE) && PAGE1_PRESENT) begin
      case (offset_q)
        OFF_FW_MAJOR: map_byte = FW_MAJOR;
        OFF_FW_MINOR: map_byte = FW_MINOR;
        OFF_HW_MAJOR: map_byte = HW_MAJOR;
        OFF_HW_MINOR: map_byte = HW_MINOR;
        OFF_SMF_LEN: map_byte = SMF_BYTE;
        OFF_MM5_LEN: map_byte = MM5_BYTE;
        OFF_MM4_LEN: map_byte = MM4_BYTE;
        OFF_MM3_LEN: map_byte = MM3_BYTE;
        OFF_MM2_LEN: map_byte = MM2_BYTE;
        OFF_WAVE_MSB: map_byte = WAVELENGTH[15:8];
        OFF_WAVE_LSB: map_byte = WAVELENGTH[7:0];
        OFF_TOL_MSB: map_byte = WAVE_TOL[15:8];
        OFF_TOL_LSB: map_byte = WAVE_TOL[7:0];
        OFF_SEL_WAIT: map_byte = WAIT_BYTE;
        OFF_PAGE1_CHECK: map_byte = PAGE1_CHECK;
        default: map_byte = RST_BYTE;
      endcase
    end
  end

  // Page one content is constant, so repeated reads return the same bytes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte_q <= RST_BYTE;
    end else begin
      rd_byte_q <= map_byte;
    end
  end

endmodule

`default_nettype wire

// ==== adv_rom_pkg.sv ====
/*
  Shared constants of the module advertising store: byte offsets of the
  management map, field positions, reset values, default contents and
  the states of the two-wire serial slave.
  Assumes it is compiled before every file that imports it.
*/
`default_nettype none

package adv_rom_pkg;

  // ************************************************************
  // Map offsets.
  // ************************************************************
  localparam logic [7:0] OFF_LOWER_STATUS = 8'h02;
  localparam logic [7:0] OFF_PAGE_SELECT = 8'h7F;
  localparam logic [7:0] OFF_UPPER_FIRST = 8'h80;
  localparam logic [7:0] OFF_FAR_END = 8'hD3;
  localparam logic [7:0] OFF_MEDIA_TECH = 8'hD4;
  localparam logic [7:0] OFF_CUSTOM_BYTE = 8'hDD;
  localparam logic [7:0] OFF_PAGE0_CHECK = 8'hDE;
  localparam logic [7:0] OFF_NV_FIRST = 8'hDF;
  localparam logic [7:0] OFF_FW_MAJOR = 8'h80;
  localparam logic [7:0] OFF_FW_MINOR = 8'h81;
  localparam logic [7:0] OFF_HW_MAJOR = 8'h82;
  localparam logic [7:0] OFF_HW_MINOR = 8'h83;
  localparam logic [7:0] OFF_SMF_LEN = 8'h84;
  localparam logic [7:0] OFF_MM5_LEN = 8'h85;
  localparam logic [7:0] OFF_MM4_LEN = 8'h86;
  localparam logic [7:0] OFF_MM3_LEN = 8'h87;
  localparam logic [7:0] OFF_MM2_LEN = 8'h88;
  localparam logic [7:0] OFF_WAVE_MSB = 8'h8A;
  localparam logic [7:0] OFF_WAVE_LSB = 8'h8B;
  localparam logic [7:0] OFF_TOL_MSB = 8'h8C;
  localparam logic [7:0] OFF_TOL_LSB = 8'h8D;
  localparam logic [7:0] OFF_SEL_WAIT = 8'h8F;
  localparam logic [7:0] OFF_PAGE1_CHECK = 8'hFF;

  // ************************************************************
  // Field positions, codes and sizes.
  // ************************************************************
  localparam int FLAT_MEM_BIT = 7;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] PAGE_ONE = 8'h01;
  localparam logic [4:0] FAR_END_FIRST_RSVD = 5'h1B;
  localparam logic [7:0] MEDIA_FIRST_RSVD = 8'h10;
  localparam logic [7:0] MEDIA_OTHERS = 8'h08;
  localparam logic [1:0] SMF_MULT_TENTH = 2'h0;
  localparam logic [1:0] SMF_MULT_ONE = 2'h1;
  localparam int NV_DEPTH = 33;
  localparam int NV_AW = 6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] PIN_IDLE = 3'h7;

  // ************************************************************
  // Reset values and default contents.
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] DEF_BUS_ADDR = 7'h50;
  localparam logic [4:0] DEF_FAR_END = 5'h00;
  localparam logic [7:0] DEF_MEDIA_TECH = 8'h08;
  localparam logic [7:0] DEF_CUSTOM_BYTE = 8'h00;
  localparam logic [7:0] DEF_PAGE0_LOW_SUM = 8'h00;
  localparam logic [7:0] DEF_REVISION = 8'h01;
  localparam logic [1:0] DEF_SMF_MULT = 2'h1;
  localparam logic [5:0] DEF_SMF_BASE = 6'h0A;
  localparam logic [7:0] DEF_MM_LEN = 8'h00;
  localparam logic [15:0] DEF_WAVELENGTH = 16'h6626;
  localparam logic [15:0] DEF_WAVE_TOL = 16'h251C;
  localparam logic [2:0] DEF_WAIT_EXP = 3'h6;
  localparam logic [4:0] DEF_WAIT_MANT = 5'h19;

  // ************************************************************
  // Serial slave states.
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_ACK,
    ST_OFFSET,
    ST_WDATA,
    ST_READ,
    ST_RACK
  } slave_state_e;

endpackage

`default_nettype wire

// ==== nv_store.sv ====
/*
  Small byte store for the custom information area.
  Assumes one clock; read data come out of a register one edge after the
  address. The array itself has no reset, so its contents survive a reset.
*/
`timescale 1ns/1ps
`default_nettype none

module nv_store (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [adv_rom_pkg::NV_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [adv_rom_pkg::NV_AW-1:0] rd_addr,
  output logic [7:0] rd_data_q
);
  import adv_rom_pkg::*;

  logic [7:0] mem [NV_DEPTH];

  // Storage is left out of reset so that it behaves as retained memory.
  always_ff @(posedge core_clk) begin
    if (wr_en && (int'(wr_addr) < NV_DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= RST_BYTE;
    end else if (int'(rd_addr) < NV_DEPTH) begin
      rd_data_q <= mem[rd_addr];
    end else begin
      rd_data_q <= RST_BYTE;
    end
  end

endmodule

`default_nettype wire

// ==== adv_rom_checker.sv ====
/*
  Port checker for the advertising store: drive timing on the data line.
  Assumes the bench changes pins away from the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module adv_rom_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic module_select_line_n,
  input wire logic nv_prog_we,
  input wire logic [adv_rom_pkg::NV_AW-1:0] nv_prog_addr,
  input wire logic [7:0] nv_prog_data,
  input wire logic sda_o,
  input wire logic sda_oe
);
  logic scl_q;
  logic [7:0] fall_age_q;
  logic [7:0] high_age_q;
  logic [7:0] sel_age_q;

  // Cycles since the serial clock last fell, saturating.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      fall_age_q <= 8'hFF;
    end else begin
      scl_q <= scl_i;
      if (scl_q && !scl_i) begin
        fall_age_q <= 8'h00;
      end else if (fall_age_q != 8'hFF) begin
        fall_age_q <= fall_age_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_age_q <= 8'h00;
    end else if (!scl_i) begin
      high_age_q <= 8'h00;
    end else if (high_age_q != 8'hFF) begin
      high_age_q <= high_age_q + 8'h01;
    end
  end

  // Cycles the select line has been low; zero while it is high.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_age_q <= 8'h00;
    end else if (module_select_line_n) begin
      sel_age_q <= 8'h00;
    end else if (sel_age_q != 8'hFF) begin
      sel_age_q <= sel_age_q + 8'h01;
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_reset_release_quiet: assert property ($rose(rst_n) |-> !sda_oe [*4])
    else $error("data line driven just after reset");
  a_deselect_quiet: assert property (module_select_line_n [*6] |-> !sda_oe)
    else $error("data line driven while deselected");
  a_drive_after_fall: assert property ($rose(sda_oe) |-> fall_age_q <= 8'h08)
    else $error("drive began away from a clock fall");
  a_release_cause: assert property ($fell(sda_oe) |-> (fall_age_q <= 8'h08) || (sel_age_q < 8'h08))
    else $error("drive ended without clock fall or deselect");
  a_stable_scl_high: assert property (scl_i && high_age_q > 8'h08 && sel_age_q > 8'h0F |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  a_drive_hold_min: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data drive too short");
  a_idle_no_drive: assert property (high_age_q > 8'h30 |-> !sda_oe)
    else $error("data line driven on idle bus");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data output value not low");
endmodule

bind module_advertising_rom adv_rom_checker i_adv_rom_checker (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .module_select_line_n(module_select_line_n),
  .nv_prog_we(nv_prog_we),
  .nv_prog_addr(nv_prog_addr),
  .nv_prog_data(nv_prog_data),
  .sda_o(sda_o),
  .sda_oe(sda_oe)
);

`default_nettype wire

// ==== mgmt_host.sv ====
/*
  Host controller model on the two-wire management bus, with module select.
  Assumes a pulled-up data line resolved by the bench; signals change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module mgmt_host #(
  parameter int WAIT_CYC = 1500
) (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  output logic sel_n
);
  import adv_rom_pkg::*;
  localparam int Q = 20;
  logic [7:0] rx [$];
  int nacks;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    sel_n = 1'b1;
    nacks = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Data moves two cycles after the clock fall so it never looks like start or stop.
  task automatic put_bit(input logic b);
    tick(2);
    sda_pull = ~b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    scl = 1'b0;
  endtask

  task automatic get_bit(output logic b);
    tick(2);
    sda_pull = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q / 2);
    b = sda_line;
    tick(Q / 2);
    scl = 1'b0;
  endtask

  task automatic start_cond();
    tick(2);
    sda_pull = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_pull = 1'b1;
    tick(Q);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(2);
    sda_pull = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_pull = 1'b0;
    tick(Q);
  endtask

  task automatic send(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(a);
    if (a) begin
      nacks++;
    end
  endtask

  task automatic recv(input logic last);
    logic [7:0] b;
    logic x;
    for (int i = 7; i >= 0; i--) begin
      get_bit(x);
      b[i] = x;
    end
    put_bit(last);
    rx.push_back(b);
  endtask

  task automatic write_reg(input logic [7:0] off, input logic [7:0] d);
    start_cond();
    send({DEF_BUS_ADDR, 1'b0});
    send(off);
    send(d);
    stop_cond();
  endtask

  task automatic read_run(input logic [7:0] off, input int n);
    rx.delete();
    start_cond();
    send({DEF_BUS_ADDR, 1'b0});
    send(off);
    start_cond();
    send({DEF_BUS_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1);
    end
    stop_cond();
  endtask

  // Select is held low the advertised wait after it falls and before it rises.
  task automatic select(input logic on);
    tick(1);
    if (!on) begin
      tick(WAIT_CYC);
    end
    sel_n = ~on;
    if (on) begin
      tick(WAIT_CYC);
    end
  endtask
endmodule

`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking bench for the module advertising store, read through the host model.
  Assumes the package, checker and host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import adv_rom_pkg::*;
  localparam logic [4:0] FAR = 5'h1A;
  localparam logic [7:0] MEDIA = 8'h0F;
  localparam logic [7:0] CUST = 8'h5A;
  localparam logic [7:0] LOW_SUM = 8'h33;
  // Bytes 128 to 143 of the second page; 137 and 142 are reserved, 135 unsupported.
  localparam logic [7:0] P1 [16] = '{8'h11, 8'h22, 8'h03, 8'h04, 8'h3F, 8'hFF, 8'h80, 8'h00,
    8'hC8, 8'h00, 8'h77, 8'hDD, 8'h00, 8'h2F, 8'h00, 8'h23};
  localparam int WAIT_CYC = (3 << 1) * 250;
  logic core_clk = 1'b0;
  logic rst_n;
  logic nv_prog_we;
  logic [NV_AW-1:0] nv_prog_addr;
  logic [7:0] nv_prog_data;
  logic sda_o;
  logic sda_oe;
  logic scl;
  logic sda_pull;
  logic sel_n;
  logic alt_sel;
  logic alt_oe;
  wire sda_line;
  int bad_count;
  int compares;
  int cycles;

  assign sda_line = ~(sda_pull | sda_oe | alt_oe);
  always #2 core_clk = ~core_clk;

  module_advertising_rom #(.FAR_END_CODE(FAR), .MEDIA_TECH(MEDIA), .CUSTOM_BYTE(CUST),
    .PAGE0_LOW_SUM(LOW_SUM), .FW_MAJOR(P1[0]), .FW_MINOR(P1[1]), .HW_MAJOR(P1[2]),
    .HW_MINOR(P1[3]), .SMF_MULT(P1[4][7:6]), .SMF_BASE(P1[4][5:0]), .MM5_LEN(P1[5]),
    .MM4_LEN(P1[6]), .MM3_LEN(P1[7]), .MM2_LEN(P1[8]), .WAVELENGTH({P1[10], P1[11]}),
    .WAVE_TOL({P1[12], P1[13]}), .WAIT_EXP(P1[15][7:5]), .WAIT_MANT(P1[15][4:0])
  ) i_module_advertising_rom (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_i(scl),
    .sda_i(sda_line),
    .module_select_line_n(sel_n | alt_sel),
    .nv_prog_we(nv_prog_we),
    .nv_prog_addr(nv_prog_addr),
    .nv_prog_data(nv_prog_data),
    .sda_o(sda_o),
    .sda_oe(sda_oe)
  );

  mgmt_host #(.WAIT_CYC(WAIT_CYC)) i_mgmt_host (
    .core_clk(core_clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_pull(sda_pull),
    .sel_n(sel_n)
  );

  module_advertising_rom #(.IS_CABLE_ASSEMBLY(1'b1), .FAR_END_CODE(5'h1B),
    .MEDIA_TECH(8'h10)) i_module_advertising_rom_alt (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_i(scl),
    .sda_i(sda_line),
    .module_select_line_n(sel_n | ~alt_sel),
    .nv_prog_we(1'b0),
    .nv_prog_addr(nv_prog_addr),
    .nv_prog_data(nv_prog_data),
    .sda_o(),
    .sda_oe(alt_oe)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    compares++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic nv_write(input logic [NV_AW-1:0] a, input logic [7:0] d);
    @(negedge core_clk);
    nv_prog_we = 1'b1;
    nv_prog_addr = a;
    nv_prog_data = d;
    @(negedge core_clk);
    nv_prog_we = 1'b0;
  endtask

  task automatic t_lower_page();
    check({7'h00, sda_oe}, 8'h00, "drive after reset");
    i_mgmt_host.select(1'b1);
    i_mgmt_host.read_run(OFF_LOWER_STATUS, 1);
    check(i_mgmt_host.rx[0] & 8'h80, 8'h00, "page flag");
  endtask

  task automatic t_page0_retained();
    nv_write(6'h00, 8'hA5);
    nv_write(6'h20, 8'h3C);
    i_mgmt_host.read_run(OFF_FAR_END, 2);
    check(i_mgmt_host.rx[0], {3'h0, FAR}, "far end");
    check(i_mgmt_host.rx[1], MEDIA, "media");
    i_mgmt_host.read_run(OFF_CUSTOM_BYTE, 3);
    check(i_mgmt_host.rx[1], 8'(LOW_SUM + FAR + MEDIA + CUST), "page0 sum");
    check(i_mgmt_host.rx[2], 8'hA5, "custom first");
    i_mgmt_host.write_reg(OFF_NV_FIRST, 8'h00);
    i_mgmt_host.read_run(OFF_NV_FIRST, 1);
    check(i_mgmt_host.rx[0], 8'hA5, "custom after host write");
    i_mgmt_host.read_run(8'hFF, 1);
    check(i_mgmt_host.rx[0], 8'h3C, "custom last");
    i_mgmt_host.select(1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    i_mgmt_host.select(1'b1);
    i_mgmt_host.read_run(OFF_NV_FIRST, 1);
    check(i_mgmt_host.rx[0], 8'hA5, "custom after reset");
  endtask

  task automatic t_page1();
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 2; i < 16; i++) begin
      sum += P1[i];
    end
    i_mgmt_host.write_reg(OFF_PAGE_SELECT, PAGE_ONE);
    for (int pass = 0; pass < 2; pass++) begin
      i_mgmt_host.read_run(OFF_UPPER_FIRST, 16);
      for (int i = 0; i < 16; i++) begin
        check(i_mgmt_host.rx[i], P1[i], "page1 field");
      end
      i_mgmt_host.write_reg(OFF_WAVE_MSB, 8'h00);
    end
    i_mgmt_host.read_run(OFF_PAGE1_CHECK, 1);
    check(i_mgmt_host.rx[0], sum, "page1 sum");
    check(8'(i_mgmt_host.nacks), 8'h00, "acknowledges");
  endtask

  task automatic t_alt_codes();
    i_mgmt_host.select(1'b0);
    alt_sel = 1'b1;
    i_mgmt_host.select(1'b1);
    i_mgmt_host.read_run(OFF_FAR_END, 2);
    check(i_mgmt_host.rx[0], RST_BYTE, "far end");
    check(i_mgmt_host.rx[1], MEDIA_OTHERS, "media");
    i_mgmt_host.write_reg(OFF_PAGE_SELECT, PAGE_ONE);
    i_mgmt_host.read_run(OFF_SMF_LEN, 1);
    check(i_mgmt_host.rx[0], RST_BYTE, "cable smf");
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    nv_prog_we = 1'b0;
    alt_sel = 1'b0;
    nv_prog_addr = '0;
    nv_prog_data = 8'h00;
    bad_count = 0;
    compares = 0;
    cycles = 0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge core_clk);
    t_lower_page();
    t_page0_retained();
    t_page1();
    t_alt_codes();
    give_verdict();
  end
endmodule

`default_nettype wire
